// ===== logic/cable_amp_gain_writer.sv
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps

module cable_amp_gain_writer
  import cagw_pkg::*;
#(
  parameter int STABLE_CYCLES = STABLE_CYC,
  parameter int HALF_CYCLES = SCLK_HALF_CYC
) (
  input wire logic clk,                 // 20 MHz master clock
  input wire logic rst_n,               // Asynchronous reset, active low
  input wire logic psel,                // APB select
  input wire logic penable,             // APB enable
  input wire logic pwrite,              // APB direction, high is write
  input wire logic [7:0] paddr,         // APB byte address
  input wire logic [31:0] pwdata,       // APB write data
  output logic [31:0] prdata,           // APB read data
  output logic pready,                  // APB ready
  output logic pslverr,                 // APB error on unmapped address
  input wire logic [PROF_W-1:0] profilePins, // Profile select pins
  output cagw_amp_s ampPort             // Amplifier 3-wire port
);

  localparam int SETTLE_W = $clog2(STABLE_CYCLES + 1);
  localparam int HALF_W = $clog2(HALF_CYCLES + 1);

  // ----------------------------------------------------------------
  // Reset and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rstSync_r;
  logic rstSync_n;
  logic [PROF_W-1:0] pinMeta_r;
  logic [PROF_W-1:0] pinSync_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_r <= 2'b00;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rstSync_n = rstSync_r[1];

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pinMeta_r <= PROF_RESET;
      pinSync_r <= PROF_RESET;
    end else begin
      pinMeta_r <= profilePins;
      pinSync_r <= pinMeta_r;
    end
  end

  // ----------------------------------------------------------------
  // Register storage and profile selection
  // ----------------------------------------------------------------
  logic [GAIN_W-1:0] gain_r [NUM_PROFILES];
  logic [PROF_W-1:0] swProfile_r;
  logic [PROF_W-1:0] profile;
  logic [GAIN_W-1:0] target;
  logic [GAIN_W-1:0] applied_r;
  logic force_r;
  cagw_state_e state_r;

  assign profile = pinSync_r ^ swProfile_r;
  assign target = gain_r[profile];

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic setupPhase;
  logic wrEn;
  logic swRst;
  logic gainHit;
  logic addrHit;
  logic [31:0] rdMux;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  assign setupPhase = psel & ~penable;
  // Unmapped writes are dropped; the error was flagged in setup
  assign wrEn = psel & penable & pready_r & pwrite & ~pslverr_r;
  assign gainHit = (paddr[7:4] == ADDR_GAIN_BASE[7:4]) &&
                   (paddr[1:0] == 2'b00);
  assign swRst = wrEn && (paddr == ADDR_CTRL) &&
                 pwdata[CTRL_SWRST_BIT];

  always_comb begin
    rdMux = 32'h0000_0000;
    addrHit = 1'b1;
    if (paddr == ADDR_CTRL) begin
      rdMux[CTRL_PROF_LSB +: PROF_W] = swProfile_r;
    end else if (paddr == ADDR_STATUS) begin
      rdMux[STAT_GAIN_LSB +: GAIN_W] = applied_r;
      rdMux[STAT_PROF_LSB +: PROF_W] = profile;
      rdMux[STAT_BUSY_BIT] = (state_r != ST_IDLE);
      rdMux[STAT_PEND_BIT] = force_r | (target != applied_r);
    end else if (gainHit) begin
      rdMux[GAIN_W-1:0] = gain_r[paddr[3:2]];
    end else begin
      addrHit = 1'b0;
    end
  end

  // Zero wait states: answer is registered during the setup cycle
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= setupPhase;
      pslverr_r <= setupPhase & ~addrHit;
      if (setupPhase) begin
        prdata_r <= pwrite ? 32'h0000_0000 : rdMux;
      end
    end
  end
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      swProfile_r <= PROF_RESET;
    end else if (swRst) begin
      swProfile_r <= PROF_RESET;
    end else if (wrEn && (paddr == ADDR_CTRL)) begin
      swProfile_r <= pwdata[CTRL_PROF_LSB +: PROF_W];
    end
  end

  for (genvar g = 0; g < NUM_PROFILES; g++) begin : g_gain
    always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
        gain_r[g] <= GAIN_RESET;
      end else if (swRst) begin
        gain_r[g] <= GAIN_RESET;
      end else if (wrEn && gainHit &&
                   (paddr[3:2] == PROF_W'(g))) begin
        gain_r[g] <= pwdata[GAIN_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  logic [SETTLE_W-1:0] settleCnt_r;
  logic [HALF_W-1:0] halfCnt_r;
  logic [2:0] bitCnt_r;
  logic [GAIN_W-1:0] cand_r;
  logic [GAIN_W-1:0] shift_r;
  cagw_amp_s amp_r;
  logic halfDone;

  assign halfDone = (halfCnt_r == HALF_W'(HALF_CYCLES - 1));

  // Work is chosen by comparing against the last sent word, so any
  // trigger raised mid-transfer is simply seen again once idle.
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state_r <= ST_IDLE;
      settleCnt_r <= '0;
      halfCnt_r <= '0;
      bitCnt_r <= 3'h0;
      cand_r <= GAIN_RESET;
      shift_r <= GAIN_RESET;
      applied_r <= GAIN_RESET;
      force_r <= 1'b1;
      amp_r <= '{ampWriteEnable_n: 1'b1, ampSclk: 1'b0, ampSdata: 1'b0};
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (force_r || (target != applied_r)) begin
            state_r <= ST_SETTLE;
            settleCnt_r <= '0;
            cand_r <= target;
          end
        end
        ST_SETTLE: begin
          if (target != cand_r) begin
            settleCnt_r <= '0;
            cand_r <= target;
          end else if (settleCnt_r == SETTLE_W'(STABLE_CYCLES - 1)) begin
            // A value that settled back to the sent word needs no write
            if (force_r || (cand_r != applied_r)) begin
              state_r <= ST_LEAD;
              shift_r <= cand_r;
              applied_r <= cand_r;
              force_r <= 1'b0;
              halfCnt_r <= '0;
              amp_r.ampWriteEnable_n <= 1'b0;
              amp_r.ampSdata <= cand_r[GAIN_W-1];
            end else begin
              state_r <= ST_IDLE;
            end
          end else begin
            settleCnt_r <= settleCnt_r + SETTLE_W'(1);
          end
        end
        ST_LEAD: begin
          if (halfDone) begin
            state_r <= ST_SHIFT;
            halfCnt_r <= '0;
            bitCnt_r <= 3'h0;
            amp_r.ampSclk <= 1'b1;
          end else begin
            halfCnt_r <= halfCnt_r + HALF_W'(1);
          end
        end
        ST_SHIFT: begin
          // No exit but the last bit: a started write never aborts
          if (halfDone) begin
            halfCnt_r <= '0;
            if (!amp_r.ampSclk) begin
              amp_r.ampSclk <= 1'b1;
            end else begin
              amp_r.ampSclk <= 1'b0;
              if (bitCnt_r == BIT_LAST) begin
                state_r <= ST_TRAIL;
              end else begin
                bitCnt_r <= bitCnt_r + 3'h1;
                shift_r <= {shift_r[GAIN_W-2:0], 1'b0};
                amp_r.ampSdata <= shift_r[GAIN_W-2];
              end
            end
          end else begin
            halfCnt_r <= halfCnt_r + HALF_W'(1);
          end
        end
        ST_TRAIL: begin
          if (halfDone) begin
            state_r <= ST_IDLE;
            halfCnt_r <= '0;
            amp_r.ampWriteEnable_n <= 1'b1;
            amp_r.ampSdata <= 1'b0;
          end else begin
            halfCnt_r <= halfCnt_r + HALF_W'(1);
          end
        end
      endcase
    end
  end
  assign ampPort = amp_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [8:0] age_r;
  logic [3:0] riseCnt_r;
  logic sclkPrev_r;

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      age_r <= 9'h000;
      riseCnt_r <= 4'h0;
      sclkPrev_r <= 1'b0;
    end else begin
      sclkPrev_r <= amp_r.ampSclk;
      if (state_r == ST_IDLE ||
          (state_r == ST_SETTLE && target != cand_r)) begin
        age_r <= 9'h000;
      end else if (age_r != 9'h1ff) begin
        age_r <= age_r + 9'h001;
      end
      if (amp_r.ampWriteEnable_n) begin
        riseCnt_r <= 4'h0;
      end else if (amp_r.ampSclk && !sclkPrev_r) begin
        riseCnt_r <= riseCnt_r + 4'h1;
      end
    end
  end

  a_hw_first_send: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    (state_r == ST_IDLE && force_r) |=> (state_r == ST_SETTLE))
    else $error("pending reset word did not start a transfer");

  a_swrst_clear: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    swRst |=> (swProfile_r == PROF_RESET && gain_r[0] == GAIN_RESET &&
               gain_r[1] == GAIN_RESET && gain_r[2] == GAIN_RESET &&
               gain_r[3] == GAIN_RESET))
    else $error("software reset left a gain or profile bit set");

  a_swrst_quiet: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    (swRst && state_r == ST_IDLE && !force_r && applied_r == GAIN_RESET)
    |=> (state_r == ST_IDLE) [*2])
    else $error("software reset from zero gain started a transfer");

  a_start_change: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    (state_r == ST_IDLE && target != applied_r) |=> (state_r == ST_SETTLE))
    else $error("changed selected gain did not start a transfer");

  a_stable_wait: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    $fell(amp_r.ampWriteEnable_n) |->
      ($past(state_r) == ST_SETTLE &&
       $past(settleCnt_r) == SETTLE_W'(STABLE_CYCLES - 1)))
    else $error("enable fell before the settle count completed");

  a_word_latest: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    $fell(amp_r.ampWriteEnable_n) |->
      (shift_r == $past(target) && applied_r == shift_r))
    else $error("sent word is not the selected profile gain");

  a_no_abort: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    $fell(amp_r.ampWriteEnable_n) |-> (!amp_r.ampWriteEnable_n) [*8])
    else $error("serial write ended early");

  a_xfer_bound: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    age_r <= 9'(XFER_MAX_CYC))
    else $error("transfer took longer than its limit");

  a_bit_count: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    $rose(amp_r.ampWriteEnable_n) |->
      ($past(riseCnt_r) == 4'(GAIN_W) && !amp_r.ampSclk))
    else $error("enable rose without exactly eight clock pulses");

  a_apb_answer: assert property (@(posedge clk) disable iff (!rstSync_n)
    setupPhase |=> (pready_r && (pslverr_r == !$past(addrHit))))
    else $error("register access not answered in the next cycle");

endmodule

// ===== logic/cagw_pkg.sv
package cagw_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_GAIN_BASE = 8'h10;
  localparam int CTRL_SWRST_BIT = 5;
  localparam int CTRL_PROF_LSB = 0;
  localparam int STAT_GAIN_LSB = 0;
  localparam int STAT_PROF_LSB = 8;
  localparam int STAT_BUSY_BIT = 10;
  localparam int STAT_PEND_BIT = 11;

  // ----------------------------------------------------------------
  // Field sizes and reset values
  // ----------------------------------------------------------------
  localparam int GAIN_W = 8;
  localparam int NUM_PROFILES = 4;
  localparam int PROF_W = 2;
  localparam logic [GAIN_W-1:0] GAIN_RESET = 8'h00;
  localparam logic [PROF_W-1:0] PROF_RESET = 2'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCLK_HALF_NS = 200;
  // Least half period, rounded up to whole cycles
  localparam int SCLK_HALF_CYC_RAW =
    (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYC =
    (SCLK_HALF_CYC_RAW < 1) ? 1 : SCLK_HALF_CYC_RAW;
  localparam int STABLE_CYC = 48;
  localparam int XFER_MAX_CYC = 200;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETTLE = 3'b001,
    ST_LEAD   = 3'b011,
    ST_SHIFT  = 3'b010,
    ST_TRAIL  = 3'b110
  } cagw_state_e;

  typedef struct packed {
    logic ampWriteEnable_n;
    logic ampSclk;
    logic ampSdata;
  } cagw_amp_s;

endpackage

// ===== test/cagw_amp_model.sv
`timescale 1ns/1ps
module cagw_amp_model
  import cagw_pkg::*;
(
  input wire cagw_amp_s amp, // Three-wire port from the writer
  output logic [7:0] word,   // Word latched at enable rise
  output int count,          // Words latched so far
  output int bits            // Clocks seen in the last frame
);
  logic [7:0] shiftQ;
  int clocks;

  initial begin
    shiftQ = 8'h00;
    clocks = 0;
    word = 8'h00;
    count = 0;
    bits = 0;
  end

  // A frame cut short shows as a clock count other than eight
  always @(negedge amp.ampWriteEnable_n) clocks <= 0;

  always @(posedge amp.ampSclk) begin
    if (amp.ampWriteEnable_n === 1'b0) begin
      shiftQ <= {shiftQ[6:0], amp.ampSdata};
      clocks <= clocks + 1;
    end
  end

  always @(posedge amp.ampWriteEnable_n) begin
    word <= shiftQ;
    count <= count + 1;
    bits <= clocks;
  end
endmodule

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
  import cagw_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] pins = 2'h0;
  cagw_amp_s amp;
  logic [7:0] ampWord;
  int ampCount;
  int ampBits;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  int tFall = 0;
  int tAcc = 0;
  logic weQ = 1'b1;
  logic [31:0] seed = 32'd3579;
  logic [7:0] gains [4];
  logic [1:0] swProf;
  logic [1:0] pinsM;
  logic [7:0] sent;
  logic [31:0] rd;
  logic er;
  logic [31:0] r;
  int k;

  always #25 clk = ~clk;

  cable_amp_gain_writer #(.STABLE_CYCLES(48), .HALF_CYCLES(4)) dut_u (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .profilePins(pins),
    .ampPort(amp));

  cagw_amp_model amp_u (.amp(amp), .word(ampWord), .count(ampCount),
    .bits(ampBits));

  // Enable fall is seen one edge late; consumers subtract that edge
  always @(posedge clk) begin
    cyc <= cyc + 1;
    weQ <= amp.ampWriteEnable_n;
    if (weQ === 1'b1 && amp.ampWriteEnable_n === 1'b0) tFall <= cyc;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] tgt();
    return gains[pinsM ^ swProf];
  endfunction

  task automatic close_out();
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, e, input string m);
    checked++;
    if (g !== e) begin
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
      miscompares++;
    end
  endtask

  task automatic chkr(input int v, lo, hi, input string m);
    checked++;
    if (v < lo || v > hi) begin
      $display("unexpected at %0t: %s is %0d", $time, m, v);
      miscompares++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      miscompares++;
      close_out();
    end
    rd = prdata;
    er = pslverr;
    tAcc = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wgain(input int g, input logic [7:0] v);
    apb(1'b1, ADDR_GAIN_BASE + 8'(4 * g), {24'h0, v});
    gains[g] = v;
  endtask

  task automatic xfer(input int t0, input logic [7:0] e);
    int c;
    int n;
    c = ampCount;
    n = 0;
    while (ampCount == c && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) begin
      miscompares++;
      close_out();
    end
    chk8(ampWord, e, "amp word");
    chkr(ampBits, 8, 8, "bits per frame");
    if (t0 >= 0) begin
      chkr(tFall - 1 - t0, 48, 64, "settle delay");
      chkr(cyc - 1 - t0, 0, 200, "transfer time");
    end
    sent = e;
  endtask

  task automatic none();
    int c;
    c = ampCount;
    repeat (210) @(posedge clk);
    chkr(ampCount - c, 0, 0, "spurious write");
  endtask

  task automatic settle(input int t0);
    if (tgt() !== sent) xfer(t0, tgt());
    else none();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    gains = '{default: 8'h00};
    swProf = 2'h0;
    pinsM = 2'h0;
    sent = 8'h00;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    xfer(-1, 8'h00);
    wgain(0, 8'hff);
    xfer(tAcc, 8'hff);
    for (int i = 0; i < 14; i++) begin
      r = rnd();
      case (r[1:0])
        2'h1: begin
          @(posedge clk);
          pins <= r[5:4];
          pinsM = r[5:4];
          tAcc = cyc;
        end
        2'h2: begin
          apb(1'b1, ADDR_CTRL, {30'h0, r[7:6]});
          swProf = r[7:6];
        end
        default: wgain(int'(r[3:2]), r[15:8]);
      endcase
      settle(tAcc);
    end
    for (k = 0; k < 4; k++) begin
      apb(1'b0, ADDR_GAIN_BASE + 8'(4 * k), 32'h0);
      chk8(rd[7:0], gains[k], "gain readback");
    end
    k = int'(pinsM ^ swProf);
    wgain(k, 8'h5a);
    for (int n = 0; n < 100 && amp.ampWriteEnable_n !== 1'b0; n++)
      @(posedge clk);
    chk8({7'h0, amp.ampWriteEnable_n}, 8'h00, "enable low");
    wgain(k, 8'ha5);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk8({6'h0, rd[11:10]}, 8'h03, "busy pending");
    xfer(-1, 8'h5a);
    xfer(-1, 8'ha5);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk8(rd[7:0], 8'ha5, "status gain");
    chk8({4'h0, rd[11:8]}, {6'h0, pinsM ^ swProf}, "status profile");
    apb(1'b1, ADDR_CTRL, 32'h23);
    gains = '{default: 8'h00};
    swProf = 2'h0;
    xfer(tAcc, 8'h00);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk8({6'h0, rd[1:0]}, 8'h00, "profile bits");
    apb(1'b0, ADDR_GAIN_BASE + 8'(4 * k), 32'h0);
    chk8(rd[7:0], 8'h00, "gain cleared");
    apb(1'b1, ADDR_CTRL, 32'h20);
    none();
    apb(1'b0, 8'h08, 32'h0);
    chk8({7'h0, er}, 8'h01, "unmapped error");
    chk8(rd[7:0], 8'h00, "unmapped data");
    wgain(k, 8'h33);
    settle(tAcc);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    gains = '{default: 8'h00};
    xfer(-1, 8'h00);
    apb(1'b0, ADDR_GAIN_BASE + 8'(4 * k), 32'h0);
    chk8(rd[7:0], 8'h00, "gain after reset");
    close_out();
  end
endmodule
